// file: shared/asr_pkg.sv
// Constants, field layouts and carriers for the sequence/result control block
package asr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RES_W = 10;
	localparam int unsigned SLOT_W = 4;
	localparam int unsigned N_RES = 16;
	localparam int unsigned LEN_W = 5;
	localparam int unsigned INT_W = 2;

	// Register indices; byte address is four times the index
	localparam int unsigned SEQ_CTRL_IDX = 3;
	localparam int unsigned START_IDX = 5;
	localparam int unsigned STATUS_IDX = 6;
	localparam int unsigned CCF_IDX = 7;
	localparam int unsigned INT_STAT_IDX = 8;
	localparam int unsigned INT_MASK_IDX = 9;
	localparam logic [ADDR_W-1:0] ADDR_SEQ_CTRL = ADDR_W'(4 * SEQ_CTRL_IDX);
	localparam logic [ADDR_W-1:0] ADDR_START = ADDR_W'(4 * START_IDX);
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(4 * STATUS_IDX);
	localparam logic [ADDR_W-1:0] ADDR_CCF = ADDR_W'(4 * CCF_IDX);
	localparam logic [ADDR_W-1:0] ADDR_INT_STAT = ADDR_W'(4 * INT_STAT_IDX);
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = ADDR_W'(4 * INT_MASK_IDX);
	// Result window: 16 words from 0x40
	localparam logic [1:0] RES_WIN_TAG = 2'h1;
	localparam int unsigned RES_WIN_MSB = 7;
	localparam int unsigned RES_WIN_LSB = 6;
	localparam int unsigned RES_IDX_MSB = 5;
	localparam int unsigned RES_IDX_LSB = 2;

	localparam logic [7:0] SEQ_CTRL_RST = 8'h20;
	localparam logic [3:0] LEN_CODE_MAX = 4'hf;
	localparam logic [LEN_W-1:0] LEN_FULL = 5'h10;
	localparam int unsigned START_SCAN_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 4;
	localparam int unsigned STAT_FROZEN_BIT = 5;
	localparam int unsigned INT_SEQ_DONE = 0;
	localparam int unsigned INT_ABORT = 1;

	typedef enum logic [1:0] {
		FRZ_RUN = 2'h0,
		FRZ_RSVD = 2'h1,
		FRZ_FINISH = 2'h2,
		FRZ_NOW = 2'h3
	} asr_frz_e;

	typedef struct packed {
		logic rsvd;
		logic [3:0] len;
		logic fifo;
		logic [1:0] frz;
	} asr_seq_ctrl_s;

	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		logic [RES_W-1:0] data;
	} asr_result_s;
endpackage

// file: core/asr_result_mem.sv
// Result register file: one write port, registered read port
`timescale 1ns/100ps
module asr_result_mem
	import asr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire asr_result_s wr_res,
	input wire logic rd_en,
	input wire logic [SLOT_W-1:0] rd_slot,
	output logic [RES_W-1:0] rd_data_q
);
	logic [RES_W-1:0] mem_q [N_RES];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_RES; i++) begin
				mem_q[i] <= '0;
			end
		end else if (wr_en) begin
			mem_q[wr_res.slot] <= wr_res.data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_q <= '0;
		end else if (rd_en) begin
			rd_data_q <= mem_q[rd_slot];
		end
	end
endmodule

// file: core/asr_seq_ctrl.sv
// Conversion sequence and result placement control with APB registers
//
// What this block does
// RULE1: Control write aborts sequence, never starts one
// RULE2: Length code 1-15 direct, zero means 16
// RULE3: Length field resets to four conversions
// RULE4: Non-FIFO: result lands at sequence position
// RULE5: FIFO: counter kept across sequences, consecutive slots
// RULE6: FIFO scanning wraps past last result slot
// RULE7: Status shows current result slot counter
// RULE8: Abort or start clears slot counter always
// RULE9: Per-slot conversion complete flag kept
// RULE10: Software should pair FIFO with scan/trigger
// RULE11: Two-bit freeze field in bits 1:0
// RULE12: Freeze codes: run, reserved, finish-halt, halt
// RULE13: Bit 7 reserved, reads zero
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module asr_seq_ctrl
	import asr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dbg_freeze,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_data,
	output logic conv_start_q,
	output logic conv_abort_q,
	output logic conv_pause,
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LAUNCH,
		ST_WAIT
	} asr_state_e;

	function automatic logic [LEN_W-1:0] seq_len(input logic [3:0] code);
		seq_len = (code == '0) ? LEN_FULL : {1'b0, code};
	endfunction

	function automatic logic [N_RES-1:0] w1c(
		input logic [N_RES-1:0] cur,
		input logic [N_RES-1:0] clr,
		input logic [N_RES-1:0] set
	);
		w1c = (cur & ~clr) | set;
	endfunction

	function automatic logic [INT_W-1:0] w1c_int(
		input logic [INT_W-1:0] cur,
		input logic [INT_W-1:0] clr,
		input logic [INT_W-1:0] set
	);
		w1c_int = (cur & ~clr) | set;
	endfunction

	// Control image with the reserved bit forced low
	function automatic asr_seq_ctrl_s ctrl_clean(input logic [DATA_W-1:0] d);
		ctrl_clean = asr_seq_ctrl_s'(d[$bits(asr_seq_ctrl_s)-1:0]);
		ctrl_clean.rsvd = 1'b0;
	endfunction

	asr_state_e state_q;
	asr_seq_ctrl_s seq_ctrl_q;
	logic scan_q;
	logic [SLOT_W-1:0] slot_q;
	logic [LEN_W-1:0] pos_q;
	logic [N_RES-1:0] ccf_q;
	logic [INT_W-1:0] int_stat_q;
	logic [INT_W-1:0] int_mask_q;
	logic [DATA_W-1:0] rdata_q;
	logic res_rd_q;
	logic hit_q;
	logic [RES_W-1:0] mem_rdata;

	logic setup;
	logic access_wr;
	logic wr_seq_ctrl;
	logic wr_start;
	logic res_win;
	logic hit;
	logic frz_block;
	logic store;
	logic last_conv;
	logic seq_done;
	logic busy;
	logic frozen;
	logic wr_ccf;
	logic wr_int_stat;
	logic wr_int_mask;
	logic [N_RES-1:0] ccf_set;
	logic [INT_W-1:0] int_set;
	asr_result_s wr_res;
	asr_frz_e frz;

	// Bus phase and register write decode
	assign setup = psel && !penable;
	assign access_wr = psel && penable && pwrite;
	assign wr_seq_ctrl = access_wr && (paddr == ADDR_SEQ_CTRL);
	assign wr_start = access_wr && (paddr == ADDR_START);
	assign wr_ccf = access_wr && (paddr == ADDR_CCF);
	assign wr_int_stat = access_wr && (paddr == ADDR_INT_STAT);
	assign wr_int_mask = access_wr && (paddr == ADDR_INT_MASK);
	assign res_win = (paddr[RES_WIN_MSB:RES_WIN_LSB] == RES_WIN_TAG);
	assign frz = asr_frz_e'(seq_ctrl_q.frz);

	// Mapped addresses; anything else answers with an error
	always_comb begin
		case (paddr)
			ADDR_SEQ_CTRL,
			ADDR_START,
			ADDR_STATUS,
			ADDR_CCF,
			ADDR_INT_STAT,
			ADDR_INT_MASK: hit = 1'b1;
			default: hit = res_win;
		endcase
	end

	// Freeze decode; reserved code behaves as run
	always_comb begin
		case (frz)
			FRZ_FINISH: frz_block = dbg_freeze; // [RULE11] [RULE12]
			FRZ_NOW: frz_block = dbg_freeze; // [RULE12]
			default: frz_block = 1'b0; // [RULE12]
		endcase
	end

	// Immediate freeze pauses a conversion in flight
	assign conv_pause = dbg_freeze && (frz == FRZ_NOW) && (state_q == ST_WAIT); // [RULE12]

	// A control or start write in the same cycle wins: that result is dropped
	assign store = (state_q == ST_WAIT) && conv_done && !conv_pause && !wr_seq_ctrl && !wr_start;
	assign last_conv = (pos_q == seq_len(seq_ctrl_q.len) - LEN_W'(1)); // [RULE2]
	assign seq_done = store && last_conv;

	// Busy from the start write until the last result is stored (never in scan mode) or a control register write
	assign busy = (state_q != ST_IDLE);
	assign frozen = frz_block && busy;

	assign wr_res.slot = slot_q;
	assign wr_res.data = conv_data;

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			conv_start_q <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			if (wr_start) begin
				state_q <= ST_LAUNCH;
			end else if (wr_seq_ctrl) begin
				state_q <= ST_IDLE; // [RULE1]
			end else begin
				case (state_q)
					ST_IDLE: begin
						state_q <= ST_IDLE;
					end
					ST_LAUNCH: begin
						if (!frz_block) begin
							conv_start_q <= 1'b1;
							state_q <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (store) begin
							if (last_conv && !scan_q) begin
								state_q <= ST_IDLE;
							end else begin
								state_q <= ST_LAUNCH;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Abort strobe to the analog side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_abort_q <= 1'b0;
		end else begin
			conv_abort_q <= (wr_seq_ctrl || wr_start) && busy; // [RULE1]
		end
	end

	// Position within the current sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_q <= '0;
		end else if (wr_seq_ctrl || wr_start) begin
			pos_q <= '0;
		end else if (store) begin
			pos_q <= last_conv ? '0 : pos_q + LEN_W'(1);
		end
	end

	// Result slot counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_q <= '0;
		end else if (wr_seq_ctrl || wr_start) begin
			slot_q <= '0; // [RULE8]
		end else if (seq_done && !seq_ctrl_q.fifo) begin
			slot_q <= '0; // [RULE4]
		end else if (store) begin
			// Four-bit counter wraps from 15 to 0
			slot_q <= slot_q + SLOT_W'(1); // [RULE4] [RULE5] [RULE6]
		end
	end

	// Sequence control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_ctrl_q <= asr_seq_ctrl_s'(SEQ_CTRL_RST); // [RULE3]
		end else if (wr_seq_ctrl) begin
			seq_ctrl_q <= ctrl_clean(pwdata); // [RULE13]
		end
	end

	// Scan mode latched by the start write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q <= 1'b0;
		end else if (wr_start) begin
			scan_q <= pwdata[START_SCAN_BIT];
		end
	end

	// Conversion complete flags, set wins over clear
	always_comb begin
		ccf_set = '0;
		if (store) begin
			ccf_set[slot_q] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccf_q <= '0;
		end else if (wr_ccf) begin
			ccf_q <= w1c(ccf_q, pwdata[N_RES-1:0], ccf_set); // [RULE9]
		end else begin
			ccf_q <= ccf_q | ccf_set; // [RULE9]
		end
	end

	// Interrupt status and mask
	always_comb begin
		int_set = '0;
		int_set[INT_SEQ_DONE] = seq_done;
		int_set[INT_ABORT] = conv_abort_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= '0;
		end else if (wr_int_stat) begin
			// Set wins over clear so an event in the clear cycle is kept
			int_stat_q <= w1c_int(int_stat_q, pwdata[INT_W-1:0], int_set);
		end else begin
			int_stat_q <= int_stat_q | int_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_q <= '0;
		end else if (wr_int_mask) begin
			int_mask_q <= pwdata[INT_W-1:0];
		end
	end

	assign irq = |(int_stat_q & int_mask_q);

	asr_result_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(store),
		.wr_res(wr_res),
		.rd_en(setup && res_win),
		.rd_slot(paddr[RES_IDX_MSB:RES_IDX_LSB]),
		.rd_data_q(mem_rdata)
	);

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
			res_rd_q <= 1'b0;
			hit_q <= 1'b0;
		end else if (setup) begin
			res_rd_q <= res_win;
			hit_q <= hit;
			rdata_q <= '0;
			case (paddr)
				ADDR_SEQ_CTRL: begin
					rdata_q[$bits(asr_seq_ctrl_s)-1:0] <= ctrl_clean(DATA_W'(seq_ctrl_q)); // [RULE13]
				end
				ADDR_START: begin
					rdata_q[START_SCAN_BIT] <= scan_q;
				end
				ADDR_STATUS: begin
					rdata_q[SLOT_W-1:0] <= slot_q; // [RULE7]
					rdata_q[STAT_BUSY_BIT] <= busy;
					rdata_q[STAT_FROZEN_BIT] <= frozen;
				end
				ADDR_CCF: begin
					rdata_q[N_RES-1:0] <= ccf_q; // [RULE9]
				end
				ADDR_INT_STAT: begin
					rdata_q[INT_W-1:0] <= int_stat_q;
				end
				ADDR_INT_MASK: begin
					rdata_q[INT_W-1:0] <= int_mask_q;
				end
				default: begin
					rdata_q <= '0;
				end
			endcase
		end
	end

	assign prdata = res_rd_q ? DATA_W'(mem_rdata) : rdata_q;
	assign pready = 1'b1;
	// Error decode taken at setup so it stands through the access phase
	assign pslverr = psel && penable && !hit_q;
endmodule

// file: dv/asr_seq_ctrl_assertions.sv
// Port-level checks for the sequence and result control block
`timescale 1ns/100ps
module asr_seq_ctrl_assertions
	import asr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dbg_freeze,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_data,
	input wire logic conv_start_q,
	input wire logic conv_abort_q,
	input wire logic conv_pause,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence ctrl_wr;
		psel && penable && pwrite && paddr == ADDR_SEQ_CTRL;
	endsequence
	sequence reg_rd(logic [ADDR_W-1:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	ctrl_no_start_a: assert property (ctrl_wr |=> !conv_start_q [*3])
		else $error("start after control write");
	abort_cause_a: assert property (conv_abort_q |-> $past(psel && penable && pwrite
		&& (paddr == ADDR_SEQ_CTRL || paddr == ADDR_START)))
		else $error("abort without register write");
	abort_alone_a: assert property (conv_abort_q |-> !conv_start_q)
		else $error("abort and start together");
	pause_cause_a: assert property (conv_pause |-> dbg_freeze)
		else $error("pause without freeze");
	start_pulse_a: assert property (conv_start_q |=> !conv_start_q)
		else $error("start longer than one cycle");
	ready_high_a: assert property (pready)
		else $error("ready low");
	err_zero_a: assert property (psel && penable && pslverr |-> prdata == '0)
		else $error("error read not zero");
	ctrl_rsvd_a: assert property (reg_rd(ADDR_SEQ_CTRL) |-> prdata[31:7] == '0)
		else $error("control upper bits set");
	stat_width_a: assert property (reg_rd(ADDR_STATUS) |-> prdata[31:6] == '0)
		else $error("status upper bits set");
endmodule

bind asr_seq_ctrl asr_seq_ctrl_assertions asr_seq_ctrl_assertions_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dbg_freeze(dbg_freeze), .conv_done(conv_done), .conv_data(conv_data),
	.conv_start_q(conv_start_q), .conv_abort_q(conv_abort_q), .conv_pause(conv_pause),
	.irq(irq));

// file: dv/asr_seq_ctrl_test.sv
// Self-checking bench for the sequence and result control block
`timescale 1ns/100ps
module asr_seq_ctrl_test
	import asr_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dbg_freeze = 0;
	logic conv_done = 0, pready, pslverr, conv_start_q, conv_abort_q, conv_pause, irq, rerr;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rdat;
	logic [RES_W-1:0] conv_data = '0;
	int n_fail = 0, n_tests = 0, ndone = 0, lim = 1000000, dly = 0, n0;
	asr_seq_ctrl asr_seq_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dbg_freeze(dbg_freeze), .conv_done(conv_done),
		.conv_data(conv_data), .conv_start_q(conv_start_q), .conv_abort_q(conv_abort_q),
		.conv_pause(conv_pause), .irq(irq));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	// Converter stand-in: answers each start four cycles later until lim, holds while paused
	always @(posedge pclk) begin
		conv_done <= 1'b0;
		if (conv_start_q && ndone < lim) begin
			dly <= 3;
		end else if (dly > 0 && !conv_pause) begin
			dly <= dly - 1;
			if (dly == 1) begin
				conv_done <= 1'b1;
				conv_data <= RES_W'(ndone + 'h21);
				ndone <= ndone + 1;
			end
		end
	end
	function automatic logic [31:0] dv(int n);
		return 32'(RES_W'(n + 'h21));
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, '0);
		chk(rdat, e);
	endtask
	task wirq;
		for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge pclk);
	endtask
	task t_reset;
		rd(ADDR_SEQ_CTRL, 32'h20);
		rd(ADDR_STATUS, 32'h0);
		rd(8'h3c, 32'h0);
		chk(rerr, 1'b1);
		apb(ADDR_SEQ_CTRL, 1'b1, 32'hff);
		rd(ADDR_SEQ_CTRL, 32'h7f);
	endtask
	task t_seq(input logic [31:0] ctl, input int len);
		apb(ADDR_CCF, 1'b1, 32'hffff);
		apb(ADDR_INT_STAT, 1'b1, 32'h3);
		apb(ADDR_INT_MASK, 1'b1, 32'h1);
		apb(ADDR_SEQ_CTRL, 1'b1, ctl);
		n0 = ndone;
		apb(ADDR_START, 1'b1, 32'h0);
		wirq();
		chk(irq, 1'b1);
		rd(ADDR_CCF, 32'((1 << len) - 1));
		for (int k = 0; k < len; k++) rd(ADDR_SEQ_CTRL + 8'h34 + 8'(4 * k), dv(n0 + k));
		rd(ADDR_STATUS, 32'h0);
	endtask
	task t_fifo;
		apb(ADDR_INT_STAT, 1'b1, 32'h3);
		apb(ADDR_SEQ_CTRL, 1'b1, 32'h14);
		n0 = ndone;
		lim = n0 + 18;
		apb(ADDR_START, 1'b1, 32'h1);
		for (int k = 0; k < 3000 && ndone != lim; k++) @(posedge pclk);
		repeat (6) @(posedge pclk);
		rd(ADDR_STATUS, 32'h12);
		rd(8'h40, dv(n0 + 16));
		rd(8'h44, dv(n0 + 17));
		rd(8'h48, dv(n0 + 2));
		apb(ADDR_SEQ_CTRL, 1'b1, 32'h14);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_INT_STAT, 32'h3);
		chk(irq, 1'b1);
		apb(ADDR_INT_MASK, 1'b1, 32'h0);
		chk(irq, 1'b0);
		apb(ADDR_INT_STAT, 1'b1, 32'h3);
		apb(ADDR_INT_MASK, 1'b1, 32'h1);
		chk(irq, 1'b0);
		lim = 1000000;
	endtask
	task t_freeze;
		for (int c = 0; c < 4; c++) begin
			apb(ADDR_INT_STAT, 1'b1, 32'h3);
			dbg_freeze <= 1'b1;
			apb(ADDR_SEQ_CTRL, 1'b1, 32'h08 | 32'(c));
			apb(ADDR_START, 1'b1, 32'h0);
			repeat (30) @(posedge pclk);
			rd(ADDR_INT_STAT, 32'(c < 2));
			dbg_freeze <= 1'b0;
			wirq();
			chk(irq, 1'b1);
		end
	endtask
	task t_pause;
		apb(ADDR_INT_STAT, 1'b1, 32'h3);
		apb(ADDR_CCF, 1'b1, 32'hffff);
		apb(ADDR_SEQ_CTRL, 1'b1, 32'h12);
		apb(ADDR_START, 1'b1, 32'h0);
		dbg_freeze <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(conv_pause, 1'b0);
		repeat (18) @(posedge pclk);
		rd(ADDR_CCF, 32'h1);
		rd(ADDR_STATUS, 32'h31);
		dbg_freeze <= 1'b0;
		wirq();
		rd(ADDR_CCF, 32'h3);
		apb(ADDR_INT_STAT, 1'b1, 32'h3);
		apb(ADDR_SEQ_CTRL, 1'b1, 32'h0b);
		apb(ADDR_START, 1'b1, 32'h0);
		dbg_freeze <= 1'b1;
		repeat (20) @(posedge pclk);
		chk(conv_pause, 1'b1);
		rd(ADDR_STATUS, 32'h30);
		rd(ADDR_INT_STAT, 32'h0);
		dbg_freeze <= 1'b0;
		wirq();
		chk(irq, 1'b1);
	endtask
	task summarize;
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_fail++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_seq(32'h18, 3);
		t_seq(32'h00, 16);
		t_fifo();
		t_freeze();
		t_pause();
		summarize();
	end
endmodule
